// ---- design/sdr_dram_device.sv ----
// Pin-level logic of a four-bank single-data-rate DRAM with its array.
// Assumes the host drives all pins synchronously to clk.
`timescale 1ns/1ps
`include "sdr_dram_regs.svh"

module sdr_write_fifo #(
  parameter int WIDTH = `DATA_W,
  parameter int DEPTH = `FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstN,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] slots;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next;
  logic push;
  logic pop;

  assign inReady = st.count != FULL;
  assign outValid = st.count != '0;
  assign outData = st.slots[st.rd];

  always_comb begin
    next = st;
    push = inValid && inReady;
    pop = outValid && outReady;
    if (push) begin
      next.slots[st.wr] = inData;
      next.wr = (st.wr == LAST) ? '0 : st.wr + 1'b1;
    end
    if (pop) begin
      next.rd = (st.rd == LAST) ? '0 : st.rd + 1'b1;
    end
    if (push && !pop) begin
      next.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      st <= '0;
    end else begin
      st <= next;
    end
  end
endmodule

module sdr_dram_device #(
  parameter int STORE_BITS = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Command pins
  input wire logic cke,
  input wire logic chipSelect_n,
  input wire logic rowStrobe_n,
  input wire logic colStrobe_n,
  input wire logic writeEnable_n,
  input wire logic [`BANK_W-1:0] bankSelect,
  input wire logic [`ROW_W-1:0] address,
  input wire logic [`LANES-1:0] byteLaneMask,
  // Data pins
  input wire logic [`DATA_W-1:0] dataBusIn,
  output logic [`DATA_W-1:0] dataBusOut,
  output logic [`LANES-1:0] dataBusOe,
  // Array write port
  input wire logic storeEnable,
  // Status
  output logic [`BANKS-1:0] bankOpen,
  output logic powerDown,
  output logic selfRefresh,
  output logic clockSuspend,
  output logic bufferFull
);
  localparam int ENTRY_W = STORE_BITS + `LANES + `DATA_W;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] resetSync;
  logic rstN;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      resetSync <= '0;
    end else begin
      resetSync <= {resetSync[0], 1'b1};
    end
  end
  assign rstN = resetSync[1];

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic sdr_dram_pkg::command_t decodeCommand(
    input logic cs, input logic ras, input logic cas, input logic we);
    sdr_dram_pkg::command_t c;
    c = sdr_dram_pkg::CMD_NOP;
    if (cs) begin
      c = sdr_dram_pkg::CMD_DESELECT;
    end else begin
      case ({ras, cas, we})
        3'h3: c = sdr_dram_pkg::CMD_OPEN;
        3'h2: c = sdr_dram_pkg::CMD_CLOSE;
        3'h4: c = sdr_dram_pkg::CMD_READ;
        3'h5: c = sdr_dram_pkg::CMD_WRITE;
        3'h0: c = sdr_dram_pkg::CMD_MODE;
        3'h1: c = sdr_dram_pkg::CMD_REFRESH;
        3'h6: c = sdr_dram_pkg::CMD_STOP;
        default: c = sdr_dram_pkg::CMD_NOP;
      endcase
    end
    return c;
  endfunction

  function automatic logic [`COL_W-1:0] burstSpan(input logic [2:0] code);
    logic [`COL_W-1:0] s;
    case (code)
      `BL_ONE: s = `SPAN_ONE;
      `BL_TWO: s = `SPAN_TWO;
      `BL_FOUR: s = `SPAN_FOUR;
      `BL_EIGHT: s = `SPAN_EIGHT;
      default: s = `SPAN_PAGE;
    endcase
    return s;
  endfunction

  function automatic logic [`COL_W-1:0] burstColumn(
    input logic [`COL_W-1:0] start, input logic [`COL_W-1:0] count,
    input logic [`COL_W-1:0] span, input logic inter);
    logic [`COL_W-1:0] low;
    low = inter ? (start ^ count) : (start + count);
    return (start & ~span) | (low & span);
  endfunction

  function automatic logic [STORE_BITS-1:0] foldAddr(
    input logic [`BANK_W-1:0] b, input logic [`ROW_W-1:0] r,
    input logic [`COL_W-1:0] c);
    logic [`BANK_W+`ROW_W+`COL_W-1:0] full;
    full = {b, r, c};
    return full[STORE_BITS-1:0];
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  sdr_dram_pkg::dev_state_t st;
  sdr_dram_pkg::dev_state_t next;
  sdr_dram_pkg::command_t cmd;
  logic run;
  logic colCmd;
  logic beatOn;
  logic beatWrite;
  logic beatClose;
  logic lastBeat;
  logic [`BANK_W-1:0] beatBank;
  logic [`COL_W-1:0] beatStart;
  logic [`COL_W-1:0] beatCount;
  logic [`COL_W-1:0] beatSpan;
  logic [`COL_W-1:0] beatCol;
  logic [STORE_BITS-1:0] readAddr;
  logic [`DATA_W-1:0] readWord;
  logic pushValid;
  logic fifoInReady;
  logic drainValid;
  logic [ENTRY_W-1:0] drainEntry;
  logic [STORE_BITS-1:0] drainAddr;
  logic [`LANES-1:0] drainMask;
  logic [`DATA_W-1:0] drainData;
  logic modeType;

  assign run = st.power == sdr_dram_pkg::PWR_RUN;
  assign cmd = decodeCommand(chipSelect_n, rowStrobe_n, colStrobe_n,
                             writeEnable_n);
  assign modeType = address[`MODE_TYPE_BIT];
  assign {drainAddr, drainMask, drainData} = drainEntry;

  // ----------------------------------------
  // Write buffer and byte-lane array
  // ----------------------------------------
  sdr_write_fifo #(.WIDTH(ENTRY_W), .DEPTH(`FIFO_DEPTH)) writeBuffer (
    .clk(clk),
    .rstN(rstN),
    .inValid(pushValid),
    .inReady(fifoInReady),
    .inData({readAddr, byteLaneMask, dataBusIn}),
    .outValid(drainValid),
    .outReady(storeEnable),
    .outData(drainEntry)
  );

  for (genvar g = 0; g < `LANES; g++) begin : lane
    logic [`LANE_W-1:0] cells [2**STORE_BITS];
    always_ff @(posedge clk) begin
      if (drainValid && storeEnable && !drainMask[g]) begin
        cells[drainAddr] <= drainData[g*`LANE_W +: `LANE_W];
      end
    end
    assign readWord[g*`LANE_W +: `LANE_W] = cells[readAddr];
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next = st;
    pushValid = 1'b0;
    colCmd = 1'b0;
    beatOn = 1'b0;
    next.ckeSync = {st.ckeSync[0], cke};
    next.bufferFull = !fifoInReady;
    colCmd = run && (cmd == sdr_dram_pkg::CMD_READ ||
             cmd == sdr_dram_pkg::CMD_WRITE) &&
             st.bankOpen[bankSelect];
    if (colCmd) begin
      beatWrite = cmd == sdr_dram_pkg::CMD_WRITE;
      beatBank = bankSelect;
      beatStart = address[`COL_W-1:0];
      beatCount = '0;
      beatClose = address[`AUTO_CLOSE_BIT];
    end else begin
      beatWrite = st.burstWrite;
      beatBank = st.burstBank;
      beatStart = st.burstStart;
      beatCount = st.burstCount;
      beatClose = st.burstClose;
    end
    beatSpan = burstSpan(st.burstCode);
    beatCol = burstColumn(beatStart, beatCount, beatSpan,
                          st.interleave && st.burstCode != `BL_PAGE);
    readAddr = foldAddr(beatBank, st.openRow[beatBank], beatCol);
    beatOn = colCmd || (run && st.burstOn &&
             cmd != sdr_dram_pkg::CMD_STOP);
    lastBeat = beatOn && beatCount == beatSpan &&
               st.burstCode != `BL_PAGE;
    case (st.power)
      sdr_dram_pkg::PWR_RUN: begin
        pushValid = beatOn && beatWrite;
        next.readValid = {st.readValid[0], beatOn && !beatWrite};
        next.readData = {st.readData[0], readWord};
        if (st.casLat == `CL_TWO) begin
          next.outValid = st.readValid[0];
          next.dataOut = st.readData[0];
        end else begin
          next.outValid = st.readValid[1];
          next.dataOut = st.readData[1];
        end
        next.dataOe = {`LANES{next.outValid}} & ~st.maskDelay;
        next.maskDelay = byteLaneMask;
        next.burstOn = beatOn && !lastBeat;
        next.burstWrite = beatWrite;
        next.burstBank = beatBank;
        next.burstStart = beatStart;
        next.burstClose = beatClose;
        next.burstCount = beatOn ? beatCount + 1'b1 : beatCount;
        if (lastBeat && beatClose) begin
          next.bankOpen[beatBank] = 1'b0;
        end
        case (cmd)
          sdr_dram_pkg::CMD_OPEN: begin
            next.bankOpen[bankSelect] = 1'b1;
            next.openRow[bankSelect] = address;
          end
          sdr_dram_pkg::CMD_CLOSE: begin
            if (address[`AUTO_CLOSE_BIT]) begin
              next.bankOpen = '0;
            end else begin
              next.bankOpen[bankSelect] = 1'b0;
            end
          end
          sdr_dram_pkg::CMD_MODE: begin
            if (st.bankOpen == '0 && !st.burstOn) begin
              next.burstCode = address[`MODE_BL_MSB:`MODE_BL_LSB];
              next.interleave = modeType;
              next.casLat = address[`MODE_CL_MSB:`MODE_CL_LSB];
            end
          end
          default: begin
            next.bankOpen = next.bankOpen;
          end
        endcase
        if (!cke) begin
          next.ckeSync = '0;
          if (next.burstOn) begin
            next.power = sdr_dram_pkg::PWR_SUSPEND;
          end else if (st.bankOpen == '0 &&
                       cmd == sdr_dram_pkg::CMD_REFRESH) begin
            next.power = sdr_dram_pkg::PWR_SELF;
          end else begin
            next.power = sdr_dram_pkg::PWR_DOWN;
          end
          if (!next.burstOn) begin
            next.dataOe = '0;
            next.outValid = 1'b0;
          end
        end
      end
      sdr_dram_pkg::PWR_SUSPEND: begin
        if (cke) begin
          next.power = sdr_dram_pkg::PWR_RUN;
        end
      end
      sdr_dram_pkg::PWR_DOWN, sdr_dram_pkg::PWR_SELF: begin
        if (st.ckeSync[1]) begin
          next.power = sdr_dram_pkg::PWR_RUN;
        end
      end
      default: begin
        next.power = sdr_dram_pkg::PWR_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      st <= sdr_dram_pkg::RESET_STATE;
    end else begin
      st <= next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign dataBusOut = st.dataOut;
  assign dataBusOe = st.dataOe;
  assign bankOpen = st.bankOpen;
  assign powerDown = st.power == sdr_dram_pkg::PWR_DOWN;
  assign selfRefresh = st.power == sdr_dram_pkg::PWR_SELF;
  assign clockSuspend = st.power == sdr_dram_pkg::PWR_SUSPEND;
  assign bufferFull = st.bufferFull;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstN);

  chk_read_latency2: assert property (
    (colCmd && cmd == sdr_dram_pkg::CMD_READ && cke &&
     st.casLat == `CL_TWO) ##1 cke |-> ##1 st.outValid)
    else $error("read data late at latency two");

  chk_read_latency3: assert property (
    (colCmd && cmd == sdr_dram_pkg::CMD_READ && cke &&
     st.casLat == `CL_THREE) ##1 cke[*2] |-> ##1 st.outValid)
    else $error("read data late at latency three");

  chk_mask_lane: assert property (
    (run && cke && byteLaneMask[0]) ##1 cke |-> ##1 !st.dataOe[0])
    else $error("masked read lane still driven");

  chk_deselect_ignored: assert property (
    run && chipSelect_n && !st.burstOn |=> $stable(st.bankOpen))
    else $error("deselected cycle changed bank state");

  chk_row_open: assert property (
    run && cmd == sdr_dram_pkg::CMD_OPEN && bankSelect == '0
    |=> st.bankOpen[0])
    else $error("row open ignored");

  chk_close_all: assert property (
    run && cmd == sdr_dram_pkg::CMD_CLOSE && address[`AUTO_CLOSE_BIT]
    |=> st.bankOpen == '0)
    else $error("close all left a bank open");

  chk_suspend_freeze: assert property (
    clockSuspend && !cke |=> $stable(st.dataOut) &&
    $stable(st.burstCount) && clockSuspend)
    else $error("suspend did not freeze");

  chk_idle_powerdown: assert property (
    run && !cke && st.bankOpen == '0 && !st.burstOn &&
    cmd == sdr_dram_pkg::CMD_NOP |=> powerDown && !dataBusOe[0])
    else $error("idle clock-enable low missed power-down");

  chk_auto_close: assert property (
    lastBeat && beatClose && beatBank == '0 && run &&
    cmd != sdr_dram_pkg::CMD_OPEN |=> !st.bankOpen[0])
    else $error("auto-close did not shut the row");

  chk_mode_type: assert property (
    run && cmd == sdr_dram_pkg::CMD_MODE && st.bankOpen == '0 &&
    !st.burstOn |=> st.interleave == $past(modeType))
    else $error("mode word not loaded");

  chk_down_hold: assert property (
    powerDown && !st.ckeSync[1] |=> powerDown)
    else $error("power-down left without clock-enable");
endmodule

// ---- design/sdr_dram_pkg.sv ----
// Types shared by the DRAM device block.
// Assumes the constants header is on the include path.
`include "sdr_dram_regs.svh"

package sdr_dram_pkg;

  typedef enum logic [1:0] {
    PWR_RUN, PWR_SUSPEND, PWR_DOWN, PWR_SELF
  } power_t;

  typedef enum logic [3:0] {
    CMD_NOP, CMD_DESELECT, CMD_OPEN, CMD_CLOSE, CMD_READ,
    CMD_WRITE, CMD_MODE, CMD_REFRESH, CMD_STOP
  } command_t;

  typedef struct packed {
    logic [2:0] burstCode;
    logic interleave;
    logic [1:0] casLat;
    logic [`BANKS-1:0] bankOpen;
    logic [`BANKS-1:0][`ROW_W-1:0] openRow;
    logic burstOn;
    logic burstWrite;
    logic burstClose;
    logic [`BANK_W-1:0] burstBank;
    logic [`COL_W-1:0] burstStart;
    logic [`COL_W-1:0] burstCount;
    power_t power;
    logic [1:0] ckeSync;
    logic [1:0] readValid;
    logic [1:0][`DATA_W-1:0] readData;
    logic [`LANES-1:0] maskDelay;
    logic outValid;
    logic [`DATA_W-1:0] dataOut;
    logic [`LANES-1:0] dataOe;
    logic bufferFull;
  } dev_state_t;

  localparam dev_state_t RESET_STATE = '{
    burstCode: `RESET_BL, casLat: `RESET_CL, power: PWR_RUN, default: '0
  };

endpackage

// ---- design/sdr_dram_regs.svh ----
// Constants for the single-data-rate DRAM device block.
// Assumes inclusion by the package, the device file and both verification files.
`ifndef SDR_DRAM_REGS_SVH
`define SDR_DRAM_REGS_SVH

// ----------------------------------------
// Array geometry
// ----------------------------------------
`define ROW_W 13
`define COL_W 9
`define BANK_W 2
`define BANKS 4
`define DATA_W 32
`define LANES 4
`define LANE_W 8
`define AUTO_CLOSE_BIT 10
`define FIFO_DEPTH 16

// ----------------------------------------
// Mode word fields and codes
// ----------------------------------------
`define MODE_BL_LSB 0
`define MODE_BL_MSB 2
`define MODE_TYPE_BIT 3
`define MODE_CL_LSB 4
`define MODE_CL_MSB 5
`define BL_ONE 3'h0
`define BL_TWO 3'h1
`define BL_FOUR 3'h2
`define BL_EIGHT 3'h3
`define BL_PAGE 3'h7
`define SPAN_ONE 9'h000
`define SPAN_TWO 9'h001
`define SPAN_FOUR 9'h003
`define SPAN_EIGHT 9'h007
`define SPAN_PAGE 9'h1FF
`define CL_TWO 2'h2
`define CL_THREE 2'h3
`define RESET_BL `BL_ONE
`define RESET_CL `CL_THREE

`endif

// ---- verification/sdr_dram_device_bench.sv ----
// Self-checking bench for the DRAM device block.
// Assumes the host model file and the design files are compiled first.
`timescale 1ns/1ps
`include "sdr_dram_regs.svh"
module sdr_dram_device_bench;
  typedef struct packed {
    logic [`LANES-1:0] oe;
    logic [`DATA_W-1:0] data;
  } note_t;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic storeEnable = 1'b1;
  logic watchOn = 1'b1;
  logic cke, chipSelect_n, rowStrobe_n, colStrobe_n, writeEnable_n;
  logic [`BANK_W-1:0] bankSelect;
  logic [`ROW_W-1:0] address;
  logic [`LANES-1:0] byteLaneMask, dataBusOe, bankOpen;
  logic [`DATA_W-1:0] dataBusIn, dataBusOut, snap, d;
  logic powerDown, selfRefresh, clockSuspend, bufferFull, sawFull;
  logic [`DATA_W-1:0] mem [0:511];
  note_t notes[$];
  int failures = 0;
  int cmp_count = 0;
  int seedDummy;

  always #12.5 clk = ~clk;

  sdr_host_model sdr_host_model_inst (.clk(clk), .cke(cke),
    .chipSelect_n(chipSelect_n), .rowStrobe_n(rowStrobe_n),
    .colStrobe_n(colStrobe_n), .writeEnable_n(writeEnable_n),
    .bankSelect(bankSelect), .address(address),
    .byteLaneMask(byteLaneMask), .dataBusIn(dataBusIn));

  sdr_dram_device sdr_dram_device_inst (.clk(clk), .reset_n(reset_n),
    .cke(cke), .chipSelect_n(chipSelect_n), .rowStrobe_n(rowStrobe_n),
    .colStrobe_n(colStrobe_n), .writeEnable_n(writeEnable_n),
    .bankSelect(bankSelect), .address(address),
    .byteLaneMask(byteLaneMask), .dataBusIn(dataBusIn),
    .dataBusOut(dataBusOut), .dataBusOe(dataBusOe),
    .storeEnable(storeEnable), .bankOpen(bankOpen), .powerDown(powerDown),
    .selfRefresh(selfRefresh), .clockSuspend(clockSuspend),
    .bufferFull(bufferFull));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] laneBits(input logic [3:0] m);
    return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
  endfunction

  task automatic check(input logic [35:0] seen, input logic [35:0] want);
    cmp_count++;
    if (seen !== want) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic bail(input bit stuck);
    if (stuck) begin
      failures++;
      print_verdict();
    end
  endtask

  task automatic cmd(input logic [3:0] c, input logic [1:0] b,
      input logic [12:0] a, input logic [3:0] m, input logic [31:0] x);
    sdr_host_model_inst.issue(c, b, a, m, x);
  endtask

  task automatic idle(input int n);
    sdr_host_model_inst.idle(n);
  endtask

  task automatic status(input logic [7:0] w);
    check({28'h0, powerDown, selfRefresh, clockSuspend, bufferFull,
      bankOpen}, {28'h0, w});
  endtask

  task automatic rd(input logic [12:0] a, input int n, input bit inter,
      input logic [3:0] mask);
    int c;
    note_t w;
    cmd(4'h4, 2'h0, a, mask, $urandom);
    for (int k = 0; k < n; k++) begin
      c = inter ? (a[8:0] ^ k) : (a[8:0] + k);
      c = (a[8:0] & ~(n - 1)) | (c & (n - 1));
      w.oe = (k == 0) ? ~mask : 4'hF;
      w.data = mem[c] & laneBits(w.oe);
      notes.push_back(w);
    end
  endtask

  task automatic settle();
    for (int i = 0; i < 40 && notes.size() > 0; i++) idle(1);
    bail(notes.size() > 0);
    idle(4);
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  // ----------------------------------------
  // Read data watcher
  // ----------------------------------------
  always @(negedge clk) begin : watch
    note_t got;
    if (watchOn && dataBusOe !== 4'h0 && notes.size() > 0) begin
      got = notes.pop_front();
      check({dataBusOe, dataBusOut & laneBits(dataBusOe)}, got);
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    seedDummy = $urandom(32'h28CC700A);
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    idle(3);
    status(8'h00);
    done("reset");
    cmd(4'h0, 2'h0, 13'h0027, 4'h0, 32'h0);
    cmd(4'h3, 2'h0, 13'h0000, 4'h0, 32'h0);
    storeEnable = 1'b0;
    sawFull = 1'b0;
    for (int k = 0; k < 20; k++) begin
      d = $urandom;
      cmd((k == 0) ? 4'h5 : 4'h7, 2'h0, 13'h0000, 4'h0, d);
      if (k < 16) mem[k] = d;
      sawFull |= bufferFull;
    end
    cmd(4'h6, 2'h0, 13'h0000, 4'h0, 32'h0);
    sawFull |= bufferFull;
    check({35'h0, sawFull}, 36'h1);
    storeEnable = 1'b1;
    for (int i = 0; i < 100 && bufferFull !== 1'b0; i++) idle(1);
    bail(bufferFull !== 1'b0);
    idle(20);
    rd(13'h0000, 16, 1'b0, 4'h0);
    idle(15);
    cmd(4'h6, 2'h0, 13'h0000, 4'h0, 32'h0);
    settle();
    done("page burst and buffer");
    d = $urandom;
    cmd(4'h5, 2'h0, 13'h0004, 4'h2, d);
    mem[4] = (d & ~laneBits(4'h2)) | (mem[4] & laneBits(4'h2));
    cmd(4'h6, 2'h0, 13'h0000, 4'h0, 32'h0);
    idle(2);
    rd(13'h0004, 1, 1'b0, 4'h1);
    cmd(4'h6, 2'h0, 13'h0000, 4'h0, 32'h0);
    settle();
    done("byte masks");
    watchOn = 1'b0;
    cmd(4'h4, 2'h0, 13'h0000, 4'h0, 32'h0);
    idle(4);
    sdr_host_model_inst.hold(1'b0);
    idle(2);
    snap = dataBusOut;
    idle(3);
    check({4'h0, dataBusOut}, {4'h0, snap});
    status(8'h21);
    sdr_host_model_inst.hold(1'b1);
    idle(3);
    cmd(4'h6, 2'h0, 13'h0000, 4'h0, 32'h0);
    idle(8);
    watchOn = 1'b1;
    done("clock suspend");
    cmd(4'h2, 2'h0, 13'h0400, 4'h0, 32'h0);
    idle(1);
    status(8'h00);
    cmd(4'h3, 2'h0, 13'h0000, 4'h0, 32'h0);
    cmd(4'h3, 2'h2, 13'h1FFF, 4'h0, 32'h0);
    idle(1);
    status(8'h05);
    cmd(4'h2, 2'h2, 13'h0000, 4'h0, 32'h0);
    cmd(4'hB, 2'h3, 13'h0000, 4'h0, 32'h0);
    cmd(4'h7, 2'h1, 13'h0000, 4'h0, 32'h0);
    idle(1);
    status(8'h01);
    done("bank open and close");
    idle(2);
    sdr_host_model_inst.hold(1'b0);
    idle(3);
    status(8'h81);
    cmd(4'h3, 2'h3, 13'h0000, 4'h0, 32'h0);
    sdr_host_model_inst.hold(1'b1);
    idle(4);
    status(8'h01);
    done("power down");
    for (int b = 0; b < 4; b++) begin
      cmd(4'h2, 2'h0, 13'h0400, 4'h0, 32'h0);
      idle(1);
      cmd(4'h0, 2'h0, 13'(b + (b % 2 + 2) * 16), 4'h0, 32'h0);
      cmd(4'h3, 2'h0, 13'h0000, 4'h0, 32'h0);
      rd(13'h0000, 1 << b, 1'b0, 4'h0);
      settle();
    end
    done("burst lengths");
    cmd(4'h2, 2'h0, 13'h0400, 4'h0, 32'h0);
    idle(1);
    cmd(4'h0, 2'h0, 13'h003A, 4'h0, 32'h0);
    cmd(4'h3, 2'h0, 13'h0000, 4'h0, 32'h0);
    rd(13'h0405, 4, 1'b1, 4'h0);
    settle();
    status(8'h00);
    done("interleave and auto close");
    cmd(4'h1, 2'h0, 13'h0000, 4'h0, 32'h0);
    sdr_host_model_inst.hold(1'b0);
    idle(3);
    status(8'h40);
    sdr_host_model_inst.hold(1'b1);
    idle(4);
    status(8'h00);
    done("self refresh");
    print_verdict();
  end
endmodule

// ---- verification/sdr_host_model.sv ----
// Host controller model driving the DRAM command and data pins.
// Assumes the bench calls its tasks; pins change on falling edges.
`timescale 1ns/1ps
`include "sdr_dram_regs.svh"
module sdr_host_model (
  // Clock
  input wire logic clk,
  // Command pins
  output logic cke,
  output logic chipSelect_n,
  output logic rowStrobe_n,
  output logic colStrobe_n,
  output logic writeEnable_n,
  output logic [`BANK_W-1:0] bankSelect,
  output logic [`ROW_W-1:0] address,
  output logic [`LANES-1:0] byteLaneMask,
  // Data pins
  output logic [`DATA_W-1:0] dataBusIn
);
  // ----------------------------------------
  // Pin state
  // ----------------------------------------
  logic [`BANKS-1:0] rowUp;

  initial begin
    cke = 1'b1;
    {chipSelect_n, rowStrobe_n, colStrobe_n, writeEnable_n} = 4'h7;
    bankSelect = 2'h0;
    address = 13'h0000;
    byteLaneMask = 4'h0;
    dataBusIn = 32'h00000000;
    rowUp = 4'h0;
  end

  // ----------------------------------------
  // Command tasks
  // ----------------------------------------
  task automatic issue(input logic [3:0] code, input logic [1:0] bank,
      input logic [12:0] addr, input logic [3:0] mask,
      input logic [31:0] data);
    logic access;
    access = (code[3:1] == 3'h2);
    @(negedge clk);
    if (access && !rowUp[bank]) code = 4'h7;
    if (code == 4'h3) rowUp[bank] = 1'b1;
    if (code == 4'h2) rowUp = addr[10] ? 4'h0 : rowUp & ~(4'h1 << bank);
    {chipSelect_n, rowStrobe_n, colStrobe_n, writeEnable_n} = code;
    bankSelect = bank;
    address = addr;
    byteLaneMask = mask;
    dataBusIn = (code == 4'h5 || code == 4'h7) ? data : ~dataBusIn;
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk);
      {chipSelect_n, rowStrobe_n, colStrobe_n, writeEnable_n} = 4'h7;
      byteLaneMask = 4'h0;
      dataBusIn = ~dataBusIn;
    end
  endtask

  task automatic hold(input logic v);
    cke = v;
  endtask
endmodule
